// ---- design/timer_special_modes.sv ----
`timescale 1ns/10ps
module timer_special_modes (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM register slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Channel pins and triggers
  input wire logic channel_one_pin,
  input wire logic channel_two_pin,
  input wire logic trigger_in,
  input wire logic ext_trigger_filtered,
  // Outputs
  output logic compare_reference,
  output logic irq,
  output logic dma_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cnt_en;
    logic count_direction;
    logic one_shot_enable;
    logic upd_dis;
    logic [2:0] slave_function_select;
    logic trig_sel;
    logic [3:0] irq_en;
    logic [3:0] dma_en;
    logic [3:0] status;
    logic [1:0] ch1_sel;
    logic [2:0] compare_output_mode;
    logic reference_clear_enable;
    logic [1:0] ch2_sel;
    logic [3:0] input_a_filter;
    logic [3:0] input_b_filter;
    logic input_a_polarity;
    logic input_b_polarity;
    logic [15:0] count_value;
    logic [15:0] psc;
    logic [15:0] psc_sh;
    logic [15:0] psc_cnt;
    logic [15:0] reload_value;
    logic [15:0] reload_sh;
    logic [15:0] cc1;
    logic [15:0] cc2;
    logic [3:0] fa_cnt;
    logic [3:0] fb_cnt;
    logic fa;
    logic fb;
    logic fa_q;
    logic fb_q;
    logic trig_q;
    logic ref_lvl;
    logic ref_clr;
    logic rd_pend;
    logic [31:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;
  logic [1:0] rst_sync;
  logic rst_n_int;

  // ----------------------------------------------------------------
  // Local copies of package constants
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_L = timer_pkg::OFS_CTRL;
  localparam logic [7:0] OFS_SLAVE_L = timer_pkg::OFS_SLAVE;
  localparam logic [7:0] OFS_ENABLE_L = timer_pkg::OFS_ENABLE;
  localparam logic [7:0] OFS_STATUS_L = timer_pkg::OFS_STATUS;
  localparam logic [7:0] OFS_CHMODE_L = timer_pkg::OFS_CHMODE;
  localparam logic [7:0] OFS_COUNT_L = timer_pkg::OFS_COUNT;
  localparam logic [7:0] OFS_PRESCALE_L = timer_pkg::OFS_PRESCALE;
  localparam logic [7:0] OFS_RELOAD_L = timer_pkg::OFS_RELOAD;
  localparam logic [7:0] OFS_CC1_L = timer_pkg::OFS_CC1;
  localparam logic [7:0] OFS_CC2_L = timer_pkg::OFS_CC2;
  localparam int CTRL_EN_L = timer_pkg::CTRL_EN;
  localparam int CTRL_DIR_L = timer_pkg::CTRL_DIR;
  localparam int CTRL_ONE_SHOT_L = timer_pkg::CTRL_ONE_SHOT;
  localparam int CTRL_UPD_DIS_L = timer_pkg::CTRL_UPD_DIS;
  localparam int SLAVE_TRIG_SEL_L = timer_pkg::SLAVE_TRIG_SEL;
  localparam int DMA_EN_LSB_L = timer_pkg::DMA_EN_LSB;
  localparam int CHM_CH1_SEL_L = timer_pkg::CHM_CH1_SEL;
  localparam int CHM_OC_MODE_L = timer_pkg::CHM_OC_MODE;
  localparam int CHM_CLR_EN_L = timer_pkg::CHM_CLR_EN;
  localparam int CHM_CH2_SEL_L = timer_pkg::CHM_CH2_SEL;
  localparam int CHM_FILT_A_L = timer_pkg::CHM_FILT_A;
  localparam int CHM_FILT_B_L = timer_pkg::CHM_FILT_B;
  localparam int CHM_POL_A_L = timer_pkg::CHM_POL_A;
  localparam int CHM_POL_B_L = timer_pkg::CHM_POL_B;
  localparam int EV_UPDATE_L = timer_pkg::EV_UPDATE;
  localparam int EV_CC1_L = timer_pkg::EV_CC1;
  localparam int EV_CC2_L = timer_pkg::EV_CC2;
  localparam int EV_TRIG_L = timer_pkg::EV_TRIG;
  localparam logic [15:0] RST_RELOAD_L = timer_pkg::RST_RELOAD;
  localparam logic [15:0] RST_ZERO16_L = timer_pkg::RST_ZERO16;
  localparam logic [31:0] UNMAPPED_READ_L = timer_pkg::UNMAPPED_READ;
  localparam logic [2:0] SM_ENC_A_L = timer_pkg::SM_ENC_A;
  localparam logic [2:0] SM_ENC_B_L = timer_pkg::SM_ENC_B;
  localparam logic [2:0] SM_ENC_AB_L = timer_pkg::SM_ENC_AB;
  localparam logic [2:0] SM_RESET_L = timer_pkg::SM_RESET;
  localparam logic [2:0] SM_GATED_L = timer_pkg::SM_GATED;
  localparam logic [2:0] SM_TRIGGER_L = timer_pkg::SM_TRIGGER;
  localparam logic [1:0] CH_OUTPUT_L = timer_pkg::CH_OUTPUT;
  localparam logic [1:0] CH_DIRECT_L = timer_pkg::CH_DIRECT;
  localparam logic [1:0] CH_CROSS_L = timer_pkg::CH_CROSS;
  localparam logic [2:0] OC_FREEZE_L = timer_pkg::OC_FREEZE;
  localparam logic [2:0] OC_MATCH_HI_L = timer_pkg::OC_MATCH_HI;
  localparam logic [2:0] OC_MATCH_LO_L = timer_pkg::OC_MATCH_LO;
  localparam logic [2:0] OC_TOGGLE_L = timer_pkg::OC_TOGGLE;
  localparam logic [2:0] OC_FORCE_LO_L = timer_pkg::OC_FORCE_LO;
  localparam logic [2:0] OC_FORCE_HI_L = timer_pkg::OC_FORCE_HI;
  localparam logic [2:0] OC_PWM1_L = timer_pkg::OC_PWM1;
  localparam logic [2:0] OC_PWM2_L = timer_pkg::OC_PWM2;

  // Filter step: level changes after N+1 agreeing samples, 0 passes through
  function automatic logic [4:0] filt_step(input logic raw, input logic cur,
                                           input logic [3:0] n, input logic [3:0] c);
    logic [4:0] r;
    r = {cur, 4'h0};
    if (raw != cur) begin
      if (c >= n) begin
        r = {raw, 4'h0};
      end else begin
        r = {cur, 4'(c + 4'h1)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Asynchronous assert, synchronous release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] fstep_a;
    logic [4:0] fstep_b;
    logic a_lvl;
    logic b_lvl;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic a_edge;
    logic b_edge;
    logic cross_edge;
    logic trig_lvl;
    logic trig_rise;
    logic enc_mode;
    logic enc_step;
    logic gate_ok;
    logic tick;
    logic step;
    logic update;
    logic [3:0] ev;
    logic match;
    logic wr;
    logic [15:0] wd;
    next_s = s;
    ev = 4'h0;
    update = 1'b0;
    wr = write && !s.rd_pend;
    wd = writedata[15:0];

    // Input filters on both channel pins
    fstep_a = filt_step(channel_one_pin, s.fa, s.input_a_filter, s.fa_cnt);
    fstep_b = filt_step(channel_two_pin, s.fb, s.input_b_filter, s.fb_cnt);
    next_s.fa = fstep_a[4];
    next_s.fa_cnt = fstep_a[3:0];
    next_s.fb = fstep_b[4];
    next_s.fb_cnt = fstep_b[3:0];
    next_s.fa_q = s.fa;
    next_s.fb_q = s.fb;

    // Polarity-applied levels and edges
    a_lvl = s.fa ^ s.input_a_polarity;
    b_lvl = s.fb ^ s.input_b_polarity;
    a_rise = s.fa & ~s.fa_q;
    a_fall = ~s.fa & s.fa_q;
    b_rise = s.fb & ~s.fb_q;
    b_fall = ~s.fb & s.fb_q;
    a_edge = s.input_a_polarity ? a_fall : a_rise;
    b_edge = s.input_b_polarity ? b_fall : b_rise;
    cross_edge = s.input_a_polarity ? a_rise : a_fall;

    // Trigger source: external pin or filtered input A
    trig_lvl = s.trig_sel ? a_lvl : trigger_in;
    next_s.trig_q = trig_lvl;
    trig_rise = trig_lvl & ~s.trig_q;

    // Encoder stepping and direction
    enc_mode = (s.slave_function_select == SM_ENC_A_L) ||
               (s.slave_function_select == SM_ENC_B_L) ||
               (s.slave_function_select == SM_ENC_AB_L);
    enc_step = 1'b0;
    if (enc_mode && s.cnt_en) begin
      if ((a_rise || a_fall) && s.slave_function_select != SM_ENC_B_L) begin
        enc_step = 1'b1;
        next_s.count_direction = a_rise ? b_lvl : ~b_lvl;
      end
      if ((b_rise || b_fall) && s.slave_function_select != SM_ENC_A_L) begin
        enc_step = 1'b1;
        next_s.count_direction = b_rise ? ~a_lvl : a_lvl;
      end
    end

    // Prescaler and count enable
    gate_ok = (s.slave_function_select != SM_GATED_L) || trig_lvl;
    tick = 1'b0;
    if (s.cnt_en && gate_ok && !enc_mode) begin
      if (s.psc_cnt == s.psc_sh) begin
        next_s.psc_cnt = RST_ZERO16_L;
        tick = 1'b1;
      end else begin
        next_s.psc_cnt = s.psc_cnt + 16'h0001;
      end
    end
    step = enc_mode ? enc_step : tick;

    // Counter with wrap
    if (step) begin
      if (next_s.count_direction) begin
        if (s.count_value == RST_ZERO16_L) begin
          next_s.count_value = s.reload_sh;
          update = 1'b1;
        end else begin
          next_s.count_value = s.count_value - 16'h0001;
        end
      end else if (s.count_value >= s.reload_sh) begin
        next_s.count_value = RST_ZERO16_L;
        update = 1'b1;
      end else begin
        next_s.count_value = s.count_value + 16'h0001;
      end
    end

    // Captures take the count before any reinitialization below
    if (s.ch1_sel == CH_DIRECT_L && a_edge) begin
      next_s.cc1 = s.count_value;
      ev[EV_CC1_L] = 1'b1;
    end
    if ((s.ch2_sel == CH_DIRECT_L && b_edge) || (s.ch2_sel == CH_CROSS_L && cross_edge)) begin
      next_s.cc2 = s.count_value;
      ev[EV_CC2_L] = 1'b1;
    end

    // Slave mode reactions to the trigger edge
    if (trig_rise) begin
      unique case (s.slave_function_select)
        SM_RESET_L: begin
          next_s.count_value = s.count_direction ? s.reload_sh : RST_ZERO16_L;
          next_s.psc_cnt = RST_ZERO16_L;
          update = 1'b1;
          ev[EV_TRIG_L] = 1'b1;
        end
        SM_GATED_L: ev[EV_TRIG_L] = 1'b1;
        SM_TRIGGER_L: begin
          next_s.cnt_en = 1'b1;
          ev[EV_TRIG_L] = 1'b1;
        end
        default: ;
      endcase
    end

    // Compare match on channel one, forced modes included
    match = (s.ch1_sel == CH_OUTPUT_L) && (s.count_value == s.cc1) && s.cnt_en;
    if (match) begin
      ev[EV_CC1_L] = 1'b1;
    end

    // PWM reference from the new count, so a one-shot stop freezes it at the level of the wrapped count
    if (s.cnt_en) begin
      unique case (s.compare_output_mode)
        OC_FREEZE_L: next_s.ref_lvl = s.ref_lvl;
        OC_MATCH_HI_L: next_s.ref_lvl = match ? 1'b1 : s.ref_lvl;
        OC_MATCH_LO_L: next_s.ref_lvl = match ? 1'b0 : s.ref_lvl;
        OC_TOGGLE_L: next_s.ref_lvl = match ? ~s.ref_lvl : s.ref_lvl;
        OC_FORCE_LO_L: next_s.ref_lvl = 1'b0;
        OC_FORCE_HI_L: next_s.ref_lvl = 1'b1;
        OC_PWM1_L: next_s.ref_lvl = next_s.count_value < s.cc1;
        OC_PWM2_L: next_s.ref_lvl = next_s.count_value >= s.cc1;
      endcase
    end

    // Update event: shadows, one-shot stop, clear release
    if (update && !s.upd_dis) begin
      next_s.reload_sh = s.reload_value;
      next_s.psc_sh = s.psc;
      ev[EV_UPDATE_L] = 1'b1;
      next_s.ref_clr = 1'b0;
      if (s.one_shot_enable) begin
        next_s.cnt_en = 1'b0;
      end
    end
    // A fresh clear request wins over release on the same cycle
    if (s.reference_clear_enable && ext_trigger_filtered) begin
      next_s.ref_clr = 1'b1;
    end

    // Register writes; status bits clear on write of one, set wins
    next_s.status = s.status | ev;
    if (wr) begin
      unique case (address)
        OFS_CTRL_L: begin
          next_s.cnt_en = writedata[CTRL_EN_L];
          if (!enc_mode) begin
            next_s.count_direction = writedata[CTRL_DIR_L];
          end
          next_s.one_shot_enable = writedata[CTRL_ONE_SHOT_L];
          next_s.upd_dis = writedata[CTRL_UPD_DIS_L];
        end
        OFS_SLAVE_L: begin
          next_s.slave_function_select = writedata[2:0];
          next_s.trig_sel = writedata[SLAVE_TRIG_SEL_L];
        end
        OFS_ENABLE_L: begin
          next_s.irq_en = writedata[3:0];
          next_s.dma_en = writedata[DMA_EN_LSB_L +: 4];
        end
        OFS_STATUS_L: next_s.status = (s.status & ~writedata[3:0]) | ev;
        OFS_CHMODE_L: begin
          next_s.ch1_sel = writedata[CHM_CH1_SEL_L +: 2];
          next_s.compare_output_mode = writedata[CHM_OC_MODE_L +: 3];
          next_s.reference_clear_enable = writedata[CHM_CLR_EN_L];
          next_s.ch2_sel = writedata[CHM_CH2_SEL_L +: 2];
          next_s.input_a_filter = writedata[CHM_FILT_A_L +: 4];
          next_s.input_b_filter = writedata[CHM_FILT_B_L +: 4];
          next_s.input_a_polarity = writedata[CHM_POL_A_L];
          next_s.input_b_polarity = writedata[CHM_POL_B_L];
        end
        OFS_COUNT_L: next_s.count_value = wd;
        OFS_PRESCALE_L: next_s.psc = wd;
        OFS_RELOAD_L: next_s.reload_value = wd;
        OFS_CC1_L: next_s.cc1 = wd;
        OFS_CC2_L: next_s.cc2 = wd;
        default: ;
      endcase
    end

    // Read data is registered; answer follows one cycle later
    next_s.rd_pend = read && !s.rd_pend;
    if (read && !s.rd_pend) begin
      unique case (address)
        OFS_CTRL_L: next_s.rdata = {28'h000_0000, s.upd_dis, s.one_shot_enable,
                                    s.count_direction, s.cnt_en};
        OFS_SLAVE_L: next_s.rdata = {27'h000_0000, s.trig_sel, 1'b0,
                                     s.slave_function_select};
        OFS_ENABLE_L: next_s.rdata = {20'h0_0000, s.dma_en, 4'h0, s.irq_en};
        OFS_STATUS_L: next_s.rdata = {28'h000_0000, s.status};
        OFS_CHMODE_L: next_s.rdata = {10'h000, s.input_b_polarity, s.input_a_polarity,
                                      s.input_b_filter, s.input_a_filter, 2'b00,
                                      s.ch2_sel, 2'b00, s.reference_clear_enable,
                                      s.compare_output_mode, s.ch1_sel};
        OFS_COUNT_L: next_s.rdata = {16'h0000, s.count_value};
        OFS_PRESCALE_L: next_s.rdata = {16'h0000, s.psc};
        OFS_RELOAD_L: next_s.rdata = {16'h0000, s.reload_value};
        OFS_CC1_L: next_s.rdata = {16'h0000, s.cc1};
        OFS_CC2_L: next_s.rdata = {16'h0000, s.cc2};
        default: next_s.rdata = UNMAPPED_READ_L;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything resets to zero except the reload pair
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s <= '0;
      s.reload_value <= RST_RELOAD_L;
      s.reload_sh <= RST_RELOAD_L;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Reads stall one cycle so read data always comes from a flop
  assign waitrequest = read && !s.rd_pend;
  assign readdata = s.rdata;
  assign compare_reference = s.ref_lvl & ~s.ref_clr;
  assign irq = |(s.status & s.irq_en);
  assign dma_req = |(s.status & s.dma_en);

endmodule

// ---- inc/timer_pkg.sv ----
package timer_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLAVE = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CHMODE = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_PRESCALE = 8'h18;
  localparam logic [7:0] OFS_RELOAD = 8'h1C;
  localparam logic [7:0] OFS_CC1 = 8'h20;
  localparam logic [7:0] OFS_CC2 = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_ONE_SHOT = 2;
  localparam int CTRL_UPD_DIS = 3;
  localparam int SLAVE_TRIG_SEL = 4;
  localparam int DMA_EN_LSB = 8;
  localparam int CHM_CH1_SEL = 0;
  localparam int CHM_OC_MODE = 2;
  localparam int CHM_CLR_EN = 5;
  localparam int CHM_CH2_SEL = 8;
  localparam int CHM_FILT_A = 12;
  localparam int CHM_FILT_B = 16;
  localparam int CHM_POL_A = 20;
  localparam int CHM_POL_B = 21;

  // Event bits in status, interrupt enable and DMA enable
  localparam int EV_UPDATE = 0;
  localparam int EV_CC1 = 1;
  localparam int EV_CC2 = 2;
  localparam int EV_TRIG = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_RELOAD = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SM_OFF = 3'b000;
  localparam logic [2:0] SM_ENC_A = 3'b001;
  localparam logic [2:0] SM_ENC_B = 3'b010;
  localparam logic [2:0] SM_ENC_AB = 3'b011;
  localparam logic [2:0] SM_RESET = 3'b100;
  localparam logic [2:0] SM_GATED = 3'b101;
  localparam logic [2:0] SM_TRIGGER = 3'b110;

  localparam logic [1:0] CH_OUTPUT = 2'b00;
  localparam logic [1:0] CH_DIRECT = 2'b01;
  localparam logic [1:0] CH_CROSS = 2'b10;

  localparam logic [2:0] OC_FREEZE = 3'b000;
  localparam logic [2:0] OC_MATCH_HI = 3'b001;
  localparam logic [2:0] OC_MATCH_LO = 3'b010;
  localparam logic [2:0] OC_TOGGLE = 3'b011;
  localparam logic [2:0] OC_FORCE_LO = 3'b100;
  localparam logic [2:0] OC_FORCE_HI = 3'b101;
  localparam logic [2:0] OC_PWM1 = 3'b110;
  localparam logic [2:0] OC_PWM2 = 3'b111;

endpackage

// ---- verification/timer_props.sv ----
`timescale 1ns/10ps
module timer_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Event outputs
  input wire logic irq,
  input wire logic dma_req
);
  logic [3:0] ien;
  logic [3:0] den;
  // Mirror of the enable register, so masking can be judged at the pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ien <= 4'h0;
      den <= 4'h0;
    end else if (write && address == timer_pkg::OFS_ENABLE) begin
      ien <= writedata[3:0];
      den <= writedata[11:8];
    end
  end
  // --------
  // Checks
  // --------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  a_read_waits: assert property ($rose(read) |-> waitrequest) else $error("read not held");
  a_one_wait: assert property (read && waitrequest |=> !waitrequest) else $error("read slow");
  a_write_nowait: assert property (write |-> !waitrequest) else $error("write held");
  a_idle_nowait: assert property (!read |-> !waitrequest) else $error("idle wait");
  a_unmapped_zero: assert property (read && !waitrequest && address == 8'h30
    |-> readdata == timer_pkg::UNMAPPED_READ) else $error("unmapped data");
  a_rdata_holds: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved");
  a_upper_zero: assert property (read && !waitrequest && address >= timer_pkg::OFS_COUNT
    |-> readdata[31:16] == 16'h0000) else $error("upper half set");
  a_irq_masked: assert property (ien == 4'h0 |-> !irq) else $error("irq unmasked");
  a_dma_masked: assert property (den == 4'h0 |-> !dma_req) else $error("dma");
  a_dma_follows: assert property (ien == den |-> irq == dma_req) else $error("dma");
  // Main scenarios
  cover property (read && !waitrequest);
  cover property (irq && !dma_req);
  cover property ($rose(dma_req));
endmodule
bind timer_special_modes timer_props i_timer_props (.ref_clk, .rstn, .address, .read, .write,
  .writedata, .readdata, .waitrequest, .irq, .dma_req);

// ---- verification/enc_source.sv ----
`timescale 1ns/10ps
module enc_source #(parameter int GAP = 8) (
  // Clock
  input wire logic ref_clk,
  // Pins toward the timer
  output logic enc_input_a,
  output logic enc_input_b,
  output logic trigger_in,
  output logic ext_trigger_filtered
);
  logic [1:0] phase;
  // Idle levels
  initial begin
    phase = 2'h0;
    {enc_input_a, enc_input_b, trigger_in, ext_trigger_filtered} = 4'h0;
  end
  // One quadrature step, A leading B for up; GAP keeps each level past the filter
  task automatic step(input logic up);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    enc_input_a <= phase[1] ^ phase[0];
    enc_input_b <= phase[1];
    repeat (GAP) @(posedge ref_clk);
  endtask
  // Pulse train on input A
  task automatic pwm(input int hi, input int lo, input int n);
    repeat (n) begin
      enc_input_a <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      enc_input_a <= 1'b0;
      repeat (lo) @(posedge ref_clk);
    end
  endtask
  // Trigger and external level pulse
  task automatic hold(input logic t, input logic e, input int len);
    trigger_in <= t;
    ext_trigger_filtered <= e;
    repeat (len) @(posedge ref_clk);
    trigger_in <= 1'b0;
    ext_trigger_filtered <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, rstn, read, write, waitrequest;
  logic [7:0] address;
  logic [31:0] writedata, readdata;
  logic enc_input_a, enc_input_b, trigger_in, ext_trigger_filtered;
  logic compare_reference, irq, dma_req;
  int errors, n_compared, cyc;
  // --------
  // Parts
  // --------
  timer_special_modes i_timer_special_modes (.ref_clk, .rstn, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .channel_one_pin(enc_input_a),
    .channel_two_pin(enc_input_b), .trigger_in, .ext_trigger_filtered, .compare_reference,
    .irq, .dma_req);
  enc_source i_enc_source (.ref_clk, .enc_input_a, .enc_input_b, .trigger_in,
    .ext_trigger_filtered);
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Hang guard, far above the roughly one thousand cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish;
    end
  end
  // --------
  // Helpers
  // --------
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, lo, hi, input string m);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi, input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, lo, hi, m);
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_enc;
    logic [2:0] md [3];
    md = '{timer_pkg::SM_ENC_A, timer_pkg::SM_ENC_B, timer_pkg::SM_ENC_AB};
    rd(timer_pkg::OFS_RELOAD, 16'hFFFF, 16'hFFFF, "reload reset");
    rd(8'h30, 16'h0000, 16'h0000, "unmapped");
    wr(timer_pkg::OFS_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(timer_pkg::OFS_SLAVE, 32'(md[i]));
      wr(timer_pkg::OFS_COUNT, 32'h0000_0000);
      repeat (4) i_enc_source.step(1'b1);
      rd(timer_pkg::OFS_COUNT, i == 2 ? 4 : 2, i == 2 ? 4 : 2, "edges");
    end
    repeat (3) i_enc_source.step(1'b0);
    rd(timer_pkg::OFS_COUNT, 16'h0001, 16'h0001, "down");
    wr(timer_pkg::OFS_CTRL, 32'h0000_0001);
    rd(timer_pkg::OFS_CTRL, 16'h0003, 16'h0003, "dir locked");
    repeat (2) i_enc_source.step(1'b1);
    rd(timer_pkg::OFS_CTRL, 16'h0001, 16'h0001, "dir up");
    rd(timer_pkg::OFS_COUNT, 16'h0003, 16'h0003, "up");
    wr(timer_pkg::OFS_SLAVE, 32'h0000_0000);
    $display("encoder test done");
  endtask
  task automatic t_slave;
    logic [31:0] q;
    wr(timer_pkg::OFS_SLAVE, 32'(timer_pkg::SM_GATED));
    wr(timer_pkg::OFS_COUNT, 32'h0000_0000);
    repeat (20) @(posedge ref_clk);
    rd(timer_pkg::OFS_COUNT, 16'h0000, 16'h0000, "gate low");
    i_enc_source.hold(1'b1, 1'b0, 40);
    repeat (8) @(posedge ref_clk);
    bus(1'b0, timer_pkg::OFS_COUNT, 32'h0000_0000, q);
    chk(q, 16'h0022, 16'h002E, "gate high");
    repeat (20) @(posedge ref_clk);
    rd(timer_pkg::OFS_COUNT, q, q, "gate kept");
    wr(timer_pkg::OFS_CTRL, 32'h0000_0000);
    wr(timer_pkg::OFS_COUNT, 32'h0000_0100);
    wr(timer_pkg::OFS_SLAVE, 32'(timer_pkg::SM_TRIGGER));
    rd(timer_pkg::OFS_COUNT, 16'h0100, 16'h0100, "idle");
    i_enc_source.hold(1'b1, 1'b0, 2);
    repeat (8) @(posedge ref_clk);
    bus(1'b0, timer_pkg::OFS_COUNT, 32'h0000_0000, q);
    chk(q, 16'h0101, 16'h0120, "started");
    rd(timer_pkg::OFS_CTRL, 16'h0001, 16'h0001, "enable set");
    repeat (20) @(posedge ref_clk);
    rd(timer_pkg::OFS_COUNT, q + 16'h0012, q + 16'h0024, "runs on");
    wr(timer_pkg::OFS_CTRL, 32'h0000_0000);
    $display("slave test done");
  endtask
  task automatic t_pwm_in;
    wr(timer_pkg::OFS_CHMODE, 32'h0000_0201);
    wr(timer_pkg::OFS_SLAVE, 32'h0000_0014);
    wr(timer_pkg::OFS_CTRL, 32'h0000_0001);
    i_enc_source.pwm(30, 70, 3);
    rd(timer_pkg::OFS_CC1, 16'h005F, 16'h0069, "period");
    rd(timer_pkg::OFS_CC2, 16'h001A, 16'h0022, "duty");
    wr(timer_pkg::OFS_CTRL, 32'h0000_0000);
    $display("pwm input test done");
  endtask
  task automatic t_one;
    int rise, fall;
    wr(timer_pkg::OFS_RELOAD, 32'h0000_001E);
    wr(timer_pkg::OFS_SLAVE, 32'h0000_0004);
    i_enc_source.hold(1'b1, 1'b0, 3);
    wr(timer_pkg::OFS_SLAVE, 32'h0000_0000);
    wr(timer_pkg::OFS_CC1, 32'h0000_000A);
    for (int up = 1; up >= 0; up--) begin
      rise = -1;
      fall = -1;
      wr(timer_pkg::OFS_CHMODE, up ? 32'h0000_001C : 32'h0000_0018);
      wr(timer_pkg::OFS_COUNT, up ? 32'h0000_0000 : 32'h0000_001E);
      wr(timer_pkg::OFS_CTRL, up ? 32'h0000_0005 : 32'h0000_0007);
      for (int i = 0; i < 80; i++) begin
        @(posedge ref_clk);
        if (compare_reference === 1'b1 && rise < 0) rise = i;
        if (compare_reference === 1'b0 && rise >= 0 && fall < 0) fall = i;
      end
      chk(rise, up ? 5 : 16, up ? 13 : 24, "delay");
      chk(fall - rise, up ? 19 : 9, up ? 22 : 12, "width");
      rd(timer_pkg::OFS_CTRL, up ? 4 : 6, up ? 4 : 6, "stopped");
      rd(timer_pkg::OFS_COUNT, up ? 0 : 30, up ? 0 : 30, "frozen");
    end
    $display("one-shot test done");
  endtask
  task automatic t_force;
    wr(timer_pkg::OFS_CC1, 32'h0000_0005);
    wr(timer_pkg::OFS_ENABLE, 32'h0000_0202);
    for (int i = 0; i < 2; i++) begin
      wr(timer_pkg::OFS_CHMODE, i ? 32'h0000_0014 : 32'h0000_0010);
      wr(timer_pkg::OFS_STATUS, 32'h0000_000F);
      wr(timer_pkg::OFS_CTRL, 32'h0000_0001);
      repeat (70) @(posedge ref_clk);
      chk(compare_reference, i, i, "forced");
      chk({irq, dma_req}, 2'h3, 2'h3, "events");
      wr(timer_pkg::OFS_CTRL, 32'h0000_0000);
    end
    wr(timer_pkg::OFS_ENABLE, 32'h0000_0002);
    chk({irq, dma_req}, 2'h2, 2'h2, "dma off");
    wr(timer_pkg::OFS_ENABLE, 32'h0000_0000);
    $display("force test done");
  endtask
  task automatic t_clear;
    wr(timer_pkg::OFS_CC1, 32'h0000_0040);
    wr(timer_pkg::OFS_CHMODE, 32'h0000_0018);
    wr(timer_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (10) @(posedge ref_clk);
    i_enc_source.hold(1'b0, 1'b1, 5);
    chk(compare_reference, 1'b1, 1'b1, "clear off");
    wr(timer_pkg::OFS_CHMODE, 32'h0000_0038);
    // Known count keeps the update out of the clear window
    wr(timer_pkg::OFS_COUNT, 32'h0000_0000);
    i_enc_source.hold(1'b0, 1'b1, 3);
    chk(compare_reference, 1'b0, 1'b0, "cleared");
    repeat (40) @(posedge ref_clk);
    chk(compare_reference, 1'b1, 1'b1, "released");
    $display("clear test done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {rstn, read, write, address, writedata} = '0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_enc;
    t_slave;
    t_pwm_in;
    t_one;
    t_force;
    t_clear;
    tally_and_finish;
  end
endmodule
